/* verilog/scb_core.sv */
// How it works
// - Decode command from pins at rising edge.
// - Chip select high: no new command accepted.
// - No-operation registers nothing, running work continues.
// - Long calibration runs engine, then updates drivers.
// - Short calibration finishes within 64 cycles.
// - Activate opens addressed row in selected bank.
// - Read column from A[9:0]; A10 auto-closes.
// - On-the-fly mode: A12 low chops to four.
// - Running bursts are never interrupted.
// - Read encoding; A10 auto close, A12 chop.
// - Write targets open row of selected bank.
// - Write encoded like read, write enable low.
// - Masked byte lanes are never written.
// - Precharge closes all with A10, else one.
// - Other banks usable during auto precharge.
// - Precharge to idle, settled bank acts as no-op.
// - Refresh uses internal address, one per command.
module scb_core (
	input  wire logic                         clk_sys,
	input  wire logic                         sys_rst,
	input  wire logic                         cke,
	input  wire logic                         cs_n,
	input  wire logic                         ras_n,
	input  wire logic                         cas_n,
	input  wire logic                         we_n,
	input  wire logic [scb_pkg::BA_W-1:0]     ba,
	input  wire logic [scb_pkg::ADDR_W-1:0]   addr,
	input  wire logic [scb_pkg::DQ_W-1:0]     dq,
	input  wire logic [scb_pkg::DM_W-1:0]     dm,
	input  wire logic                         dq_valid,
	input  wire logic                         otf_enable,
	input  wire logic                         burst_length_fixed_by_mode,
	input  wire logic                         mem_ready,
	output logic                              dq_ready,
	output logic [scb_pkg::NB-1:0]            bank_open,
	output scb_pkg::scb_cmd_t                 cmd_last,
	output logic                              beat_valid,
	output logic                              beat_wr,
	output logic [scb_pkg::BA_W-1:0]          beat_bank,
	output logic [scb_pkg::ROW_W-1:0]         beat_row,
	output logic [scb_pkg::COL_W-1:0]         beat_col,
	output logic                              zq_busy,
	output logic                              cal_update,
	output logic                              ref_busy,
	output logic [scb_pkg::ROW_W-1:0]         ref_row,
	output logic                              mem_wvalid,
	output logic [scb_pkg::WB_W-1:0]          mem_wdata
);
	import scb_pkg::*;

	typedef struct packed {
		logic [NB-1:0]                 open;
		logic [NB-1:0][ROW_W-1:0]      row;
		logic [NB-1:0][PRE_W-1:0]      pre_cnt;
		scb_cmd_t                      last_cmd;
		logic [3:0]                    bst_left;
		logic                          bst_wr;
		logic                          bst_ap;
		logic                          bst_chop;
		logic [BA_W-1:0]               bst_bank;
		logic [COL_W-1:0]              bst_col;
		logic                          beat_valid;
		logic                          beat_wr;
		logic [BA_W-1:0]               beat_bank;
		logic [ROW_W-1:0]              beat_row;
		logic [COL_W-1:0]              beat_col;
		logic [CNT_W-1:0]              zq_cnt;
		logic                          zq_busy;
		logic                          zq_init_done;
		logic                          cal_update;
		logic [CNT_W-1:0]              ref_cnt;
		logic                          ref_busy;
		logic [ROW_W-1:0]              ref_row;
	} scb_core_st_t;

	scb_core_st_t st_q;
	scb_core_st_t st_d;
	scb_cmd_t     cmd;
	logic         beat_go;
	logic         wb_push;

	scb_wbuf_if #(.W(WB_W)) wb_in ();
	scb_wbuf_if #(.W(WB_W)) wb_out ();

	// Write beats queue here so a slow array port stalls the data pins.
	scb_fifo #(
		.W     (WB_W),
		.DEPTH (WB_DEPTH)
	) u_wbuf (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.push    (wb_in.snk),
		.pop     (wb_out.src)
	);

	// Closing a bank restarts its precharge timer, except when the bank is
	// already idle and settled, where the command is a no-op.
	function automatic scb_core_st_t close_bank(scb_core_st_t s, logic [BA_W-1:0] b);
		if (s.open[b] || s.pre_cnt[b] != '0) begin
			s.pre_cnt[b] = PRE_W'(RP_CYC);
		end
		s.open[b] = 1'b0;
		return s;
	endfunction

	assign cmd = scb_decode(cke, cs_n, ras_n, cas_n, we_n, addr[A_AP]);

	// Next state: timers, the burst engine, then the newly sampled command.
	always_comb begin
		st_d            = st_q;
		st_d.beat_valid = 1'b0;
		st_d.cal_update = 1'b0;
		wb_push         = 1'b0;
		beat_go         = 1'b0;
		for (int b = 0; b < NB; b++) begin
			if (st_q.pre_cnt[b] != '0) begin
				st_d.pre_cnt[b] = st_q.pre_cnt[b] - PRE_W'(1);
			end
		end
		// A write beat waits for pin data and buffer room; reads never stall.
		if (st_q.bst_left != '0) begin
			beat_go = !st_q.bst_wr || (dq_valid && wb_in.ready);
		end
		if (beat_go) begin
			wb_push         = st_q.bst_wr;
			st_d.beat_valid = 1'b1;
			st_d.beat_wr    = st_q.bst_wr;
			st_d.beat_bank  = st_q.bst_bank;
			st_d.beat_row   = st_q.row[st_q.bst_bank];
			st_d.beat_col   = st_q.bst_col;
			st_d.bst_left   = st_q.bst_left - 4'd1;
			// Chopped bursts wrap within four columns, full ones within eight.
			if (st_q.bst_chop) begin
				st_d.bst_col[1:0] = st_q.bst_col[1:0] + 2'd1;
			end else begin
				st_d.bst_col[2:0] = st_q.bst_col[2:0] + 3'd1;
			end
			if (st_q.bst_left == 4'd1 && st_q.bst_ap) begin
				st_d = close_bank(st_d, st_q.bst_bank);
			end
		end
		// Calibration engine; results move to the drivers on completion.
		if (st_q.zq_cnt != '0) begin
			st_d.zq_cnt = st_q.zq_cnt - CNT_W'(1);
			if (st_q.zq_cnt == CNT_W'(1)) begin
				st_d.zq_busy    = 1'b0;
				st_d.cal_update = 1'b1;
			end
		end
		if (st_q.ref_cnt != '0) begin
			st_d.ref_cnt = st_q.ref_cnt - CNT_W'(1);
			if (st_q.ref_cnt == CNT_W'(1)) begin
				st_d.ref_busy = 1'b0;
			end
		end
		// Deselect and no-operation leave every running operation alone.
		st_d.last_cmd = cmd;
		case (cmd)
			CMD_DES, CMD_NOP: begin
			end
			CMD_ACT: begin
				st_d.open[ba] = 1'b1;
				st_d.row[ba]  = addr[ROW_W-1:0];
			end
			CMD_RD, CMD_WR: begin
				// A command is dropped while the running burst still has beats left after this cycle, never spliced.
				if (st_d.bst_left == '0) begin
					st_d.bst_wr   = (cmd == CMD_WR);
					st_d.bst_ap   = addr[A_AP];
					st_d.bst_chop = otf_enable ? !addr[A_BC] : burst_length_fixed_by_mode;
					st_d.bst_left = st_d.bst_chop ? 4'(BC4_BEATS) : 4'(BL8_BEATS);
					st_d.bst_bank = ba;
					st_d.bst_col  = addr[COL_W-1:0];
				end
			end
			CMD_PRE: begin
				if (addr[A_AP]) begin
					for (int b = 0; b < NB; b++) begin
						st_d = close_bank(st_d, BA_W'(b));
					end
				end else begin
					st_d = close_bank(st_d, ba);
				end
			end
			CMD_REF: begin
				// Address pins are ignored; the internal row pointer advances.
				st_d.ref_cnt  = CNT_W'(RFC_CYC);
				st_d.ref_busy = 1'b1;
				st_d.ref_row  = st_q.ref_row + ROW_W'(1);
			end
			CMD_ZQCL: begin
				st_d.zq_cnt       = st_q.zq_init_done ? CNT_W'(ZQOPER_CYC)
					: CNT_W'(ZQINIT_CYC);
				st_d.zq_busy      = 1'b1;
				st_d.zq_init_done = 1'b1;
			end
			CMD_ZQCS: begin
				st_d.zq_cnt  = CNT_W'(ZQCS_CYC);
				st_d.zq_busy = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Only lanes whose mask was low carry a write strobe into the array.
	assign wb_in.valid  = wb_push;
	assign wb_in.data   = {st_q.bst_bank, st_q.row[st_q.bst_bank], st_q.bst_col, dq, ~dm};
	assign wb_out.ready = mem_ready;

	assign dq_ready   = wb_in.ready;
	assign mem_wvalid = wb_out.valid;
	assign mem_wdata  = wb_out.data;
	assign bank_open  = st_q.open;
	assign cmd_last   = st_q.last_cmd;
	assign beat_valid = st_q.beat_valid;
	assign beat_wr    = st_q.beat_wr;
	assign beat_bank  = st_q.beat_bank;
	assign beat_row   = st_q.beat_row;
	assign beat_col   = st_q.beat_col;
	assign zq_busy    = st_q.zq_busy;
	assign cal_update = st_q.cal_update;
	assign ref_busy   = st_q.ref_busy;
	assign ref_row    = st_q.ref_row;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence s_rd_chop_start;
		cmd == CMD_RD && otf_enable && !addr[A_BC] && st_q.bst_left == '0;
	endsequence

	sequence s_four_beats;
		st_q.beat_valid [*4] ##1 !st_q.beat_valid;
	endsequence

	// Clock enable low decodes as ignored, so only a live deselect counts here.
	chk_deselect_no_change: assert property (
		cke && cs_n |=> $stable(st_q.row) && st_q.last_cmd == CMD_DES)
		else $error("deselect changed bank rows");

	chk_nop_no_change: assert property (
		cmd == CMD_NOP |=> $stable(st_q.row) && $stable(st_q.ref_row))
		else $error("no-operation changed state");

	chk_act_opens_row: assert property (
		cmd == CMD_ACT |=> st_q.open[$past(ba)] && st_q.row[$past(ba)] == $past(addr))
		else $error("activate did not open the row");

	chk_zqcs_done_time: assert property (
		cmd == CMD_ZQCS |=> st_q.zq_busy [*8] ##[56:56] st_q.zq_busy ##1 st_q.cal_update)
		else $error("short calibration window wrong");

	chk_pre_all_closes: assert property (
		cmd == CMD_PRE && addr[A_AP] |=> st_q.open == '0)
		else $error("precharge all left a bank open");

	chk_rd_chop_len: assert property (
		s_rd_chop_start |-> ##2 s_four_beats)
		else $error("chopped read not four beats");

	// The bank is recovered with a delayed sample instead of a local variable.
	property p_auto_close;
		s_rd_chop_start ##0 addr[A_AP] |-> ##5 !st_q.open[$past(ba, 5)];
	endproperty
	chk_auto_close_bank: assert property (p_auto_close)
		else $error("auto precharge did not close bank");

	chk_mask_lane_strobe: assert property (
		wb_push |-> wb_in.data[DM_W-1:0] == ~dm ##1 mem_wvalid)
		else $error("masked lane given a write strobe");

	chk_refresh_row_step: assert property (
		cmd == CMD_REF |=> st_q.ref_row == $past(st_q.ref_row) + ROW_W'(1) && st_q.ref_busy)
		else $error("refresh row pointer did not advance");

	chk_pre_idle_noop: assert property (
		cmd == CMD_PRE && !addr[A_AP] && !st_q.open[ba] && st_q.pre_cnt[ba] == '0
		|=> st_q.pre_cnt[$past(ba)] == '0)
		else $error("precharge of idle bank started timer");
endmodule

/* verilog/scb_pkg.sv */
package scb_pkg;
	// Array geometry and pin widths.
	localparam int NB       = 8;
	localparam int BA_W     = 3;
	localparam int ADDR_W   = 14;
	localparam int ROW_W    = 14;
	localparam int COL_W    = 10;
	localparam int DQ_W     = 16;
	localparam int DM_W     = 2;
	localparam int WB_DEPTH = 8;

	// Address field positions that qualify commands.
	localparam int A_AP = 10;
	localparam int A_BC = 12;

	// Burst lengths in beats.
	localparam int BL8_BEATS = 8;
	localparam int BC4_BEATS = 4;

	// Clock and timing; times round up to whole cycles.
	localparam int CLK_NS     = 10;
	localparam int T_RP_NS    = 15;
	localparam int T_RFC_NS   = 160;
	localparam int RP_CYC     = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RFC_CYC    = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
	localparam int ZQCS_CYC   = 64;
	localparam int ZQOPER_CYC = 256;
	localparam int ZQINIT_CYC = 512;
	localparam int PRE_W      = 4;
	localparam int CNT_W      = 10;

	// One buffered write beat: bank, row, column, data, lane strobes.
	localparam int WB_W = BA_W + ROW_W + COL_W + DQ_W + DM_W;

	typedef enum logic [3:0] {
		CMD_DES, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
		CMD_REF, CMD_ZQCL, CMD_ZQCS, CMD_MRS, CMD_OTHER
	} scb_cmd_t;

	// Command decode from the pin levels sampled at one rising edge.
	function automatic scb_cmd_t scb_decode(logic cke, logic cs_n, logic ras_n,
			logic cas_n, logic we_n, logic a10);
		scb_cmd_t c;
		c = CMD_OTHER;
		if (!cke) begin
			c = CMD_OTHER;
		end else if (cs_n) begin
			c = CMD_DES;
		end else begin
			case ({ras_n, cas_n, we_n})
				3'b111: c = CMD_NOP;
				3'b011: c = CMD_ACT;
				3'b101: c = CMD_RD;
				3'b100: c = CMD_WR;
				3'b010: c = CMD_PRE;
				3'b001: c = CMD_REF;
				3'b000: c = CMD_MRS;
				3'b110: c = a10 ? CMD_ZQCL : CMD_ZQCS;
				default: c = CMD_OTHER;
			endcase
		end
		return c;
	endfunction
endpackage

/* verilog/scb_wbuf_if.sv */
interface scb_wbuf_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* verilog/scb_fifo.sv */
module scb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	scb_wbuf_if.snk  push,
	scb_wbuf_if.src  pop
);
	import scb_pkg::*;

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0]   cnt;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic          rdy;
		logic          vld;
	} scb_fifo_st_t;

	logic [W-1:0] mem [DEPTH];
	scb_fifo_st_t st_q;
	scb_fifo_st_t st_d;
	logic         do_push;
	logic         do_pop;

	// Pointers wrap explicitly so a depth that is not a power of two works.
	function automatic logic [AW-1:0] nxt(logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// Ready and valid are precomputed flags so both sides see flop outputs.
	always_comb begin
		st_d    = st_q;
		do_push = push.valid && st_q.rdy;
		do_pop  = pop.ready && st_q.vld;
		if (do_push) begin
			st_d.wp = nxt(st_q.wp);
		end
		if (do_pop) begin
			st_d.rp = nxt(st_q.rp);
		end
		st_d.cnt = st_q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
		st_d.rdy = st_d.cnt != (AW + 1)'(DEPTH);
		st_d.vld = st_d.cnt != '0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_q     <= '0;
			st_q.rdy <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Storage needs no reset; the count guards every read.
	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[st_q.wp] <= push.data;
		end
	end

	assign push.ready = st_q.rdy;
	assign pop.valid  = st_q.vld;
	assign pop.data   = mem[st_q.rp];
endmodule

/* dv/scb_ctl_model.sv */
// Stands in for the memory controller: drives command pins and write beats.
module scb_ctl_model (
	input  wire logic                  clk_sys,
	output logic                       cke,
	output logic                       cs_n,
	output logic                       ras_n,
	output logic                       cas_n,
	output logic                       we_n,
	output logic [scb_pkg::BA_W-1:0]   ba,
	output logic [scb_pkg::ADDR_W-1:0] addr,
	output logic [scb_pkg::DQ_W-1:0]   dq,
	output logic [scb_pkg::DM_W-1:0]   dm,
	output logic                       dq_valid,
	input  wire logic                  dq_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	import scb_pkg::*;

	logic took;

	// Remember whether the last rising edge consumed the beat on the pins.
	always @(posedge clk_sys) begin
		took <= dq_valid & dq_ready;
	end

	// Pins start deselected so nothing is registered before reset ends.
	initial begin
		{cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
		ba = 3'h0;
		addr = 14'h0000;
		dq = 16'h0000;
		dm = 2'h0;
		dq_valid = 1'b0;
	end

	// One command for exactly one edge, then a no-operation; the released
	// address shows the inverse so a stale value can never look valid.
	task automatic cmd(input logic [4:0] p, input logic [2:0] b, input logic [13:0] a);
		@(negedge clk_sys);
		{cke, cs_n, ras_n, cas_n, we_n} = p;
		ba = b;
		addr = a;
		@(negedge clk_sys);
		{cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
		ba = ~b;
		addr = ~a;
	endtask

	// Hold one beat until an edge takes it; bounded so a stall cannot hang.
	task automatic beat(input logic [15:0] d, input logic [1:0] m, output logic ok);
		dq = d;
		dm = m;
		dq_valid = 1'b1;
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			@(negedge clk_sys);
			ok = took;
		end
	endtask

	task automatic idle_dq();
		dq_valid = 1'b0;
		dq = ~dq;
	endtask
endmodule

/* dv/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scb_pkg::*;

	localparam logic [4:0] P_ACT = 5'h13;
	localparam logic [4:0] P_RD  = 5'h15;
	localparam logic [4:0] P_WR  = 5'h14;
	localparam logic [4:0] P_PRE = 5'h12;
	localparam logic [4:0] P_REF = 5'h11;
	localparam logic [4:0] P_ZQ  = 5'h16;

	logic             clk_sys = 1'b0;
	logic             sys_rst, cke, cs_n, ras_n, cas_n, we_n, dq_valid, dq_ready;
	logic             otf_enable, burst_length_fixed_by_mode, mem_ready, mem_wvalid;
	logic [2:0]       ba, beat_bank;
	logic [13:0]      addr, beat_row, ref_row, r0;
	logic [15:0]      dq;
	logic [1:0]       dm;
	logic [7:0]       bank_open, open_m;
	scb_cmd_t         cmd_last;
	logic             beat_valid, beat_wr, zq_busy, cal_update, ref_busy, stall, full_seen;
	logic [9:0]       beat_col;
	logic [44:0]      mem_wdata;
	logic [13:0]      row_m [8];
	logic [27:0]      bq[$];
	logic [44:0]      wq[$];
	logic [44:0]      ew[$];
	logic [2:0]       b;
	int               err_count, n_tests, cyc, zc, rc, uc;
	int               seed = 50038;

	scb_core DUT (.clk_sys, .sys_rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq,
		.dm, .dq_valid, .otf_enable, .burst_length_fixed_by_mode, .mem_ready, .dq_ready,
		.bank_open, .cmd_last, .beat_valid, .beat_wr, .beat_bank, .beat_row, .beat_col,
		.zq_busy, .cal_update, .ref_busy, .ref_row, .mem_wvalid, .mem_wdata);

	scb_ctl_model ctl (.clk_sys, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq, .dm,
		.dq_valid, .dq_ready);

	always #5 clk_sys = ~clk_sys;

	// Outputs are logged at the falling edge, where they have settled.
	always @(negedge clk_sys) begin
		if (beat_valid === 1'b1) begin
			bq.push_back({beat_wr, beat_bank, beat_row, beat_col});
		end
		zc += (zq_busy === 1'b1);
		rc += (ref_busy === 1'b1);
		uc += (cal_update === 1'b1);
		if (dq_ready === 1'b0) begin
			full_seen <= 1'b1;
		end
		mem_ready <= (stall && !full_seen) ? 1'b0 : 1'($random(seed));
	end

	// Words leave the buffer only on an edge where both sides agree.
	always @(posedge clk_sys) begin
		if (mem_wvalid === 1'b1 && mem_ready) begin
			wq.push_back(mem_wdata);
		end
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
			err_count++;
		end
	endtask

	// Column of beat i: low bits wrap inside the four or eight beat group.
	function automatic logic [9:0] ecol(logic [9:0] s, int i, logic c4);
		return c4 ? {s[9:2], 2'(s[1:0] + i)} : {s[9:3], 3'(s[2:0] + i)};
	endfunction

	task automatic pre(input logic [2:0] bk, input logic all);
		ctl.cmd(P_PRE, bk, {3'h0, all, 10'h000});
		if (all) open_m = 8'h00;
		else open_m[bk] = 1'b0;
		repeat (RP_CYC + 1) @(negedge clk_sys);
		chk("bank_open", open_m, bank_open);
	endtask

	task automatic act(input logic [2:0] bk, input logic [13:0] r);
		if (open_m[bk]) pre(bk, 1'b0);
		ctl.cmd(P_ACT, bk, r);
		open_m[bk] = 1'b1;
		row_m[bk] = r;
		chk("bank_open", open_m, bank_open);
		chk("cmd_last", CMD_ACT, cmd_last);
	endtask

	task automatic burst(input logic wr, input logic [2:0] bk, input logic [9:0] c,
			input logic ap, input logic a12, input logic intr);
		logic c4;
		int n;
		logic ok;
		logic [15:0] d;
		logic [1:0] m;
		c4 = otf_enable ? !a12 : burst_length_fixed_by_mode;
		n = c4 ? BC4_BEATS : BL8_BEATS;
		bq.delete();
		ctl.cmd(wr ? P_WR : P_RD, bk, {1'b0, a12, 1'b0, ap, c});
		if (intr) ctl.cmd(P_RD, bk, 14'h0000);
		for (int i = 0; i < n && wr; i++) begin
			d = 16'($random(seed));
			m = 2'($random(seed));
			ew.push_back({bk, row_m[bk], ecol(c, i, c4), d, ~m});
			ctl.beat(d, m, ok);
			chk("beat taken", 1, ok);
		end
		if (wr) ctl.idle_dq();
		repeat (12) @(negedge clk_sys);
		chk("beat count", n, bq.size());
		for (int i = 0; i < n; i++) begin
			chk("beat", {wr, bk, row_m[bk], ecol(c, i, c4)}, bq[i]);
		end
		if (ap) open_m[bk] = 1'b0;
		chk("bank_open", open_m, bank_open);
	endtask

	// Calibration runs its full window even while deselect and no-op arrive.
	task automatic zq(input logic a10, input int n);
		zc = 0;
		uc = 0;
		ctl.cmd(P_ZQ, 3'h0, {3'h0, a10, 10'h000});
		ctl.cmd(5'h1B, 3'h0, 14'h0000);
		repeat (n + 8) @(negedge clk_sys);
		chk("zq_busy cycles", n, zc);
		chk("cal_update", 1, uc);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		logic [4:0] pat [4] = '{5'h1B, 5'h17, 5'h03, 5'h10};
		scb_cmd_t   ecmd [4] = '{CMD_DES, CMD_NOP, CMD_OTHER, CMD_MRS};
		sys_rst = 1'b1;
		stall = 1'b0;
		full_seen = 1'b0;
		mem_ready = 1'b0;
		otf_enable = 1'b1;
		burst_length_fixed_by_mode = 1'b0;
		open_m = 8'h00;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		chk("dq_ready", 1, dq_ready);
		// Deselect, no-op, clock-enable-low activate and mode set open nothing.
		for (int i = 0; i < 4; i++) begin
			ctl.cmd(pat[i], 3'h2, 14'h0155);
			chk("cmd_last", ecmd[i], cmd_last);
			chk("bank_open", 8'h00, bank_open);
		end
		zq(1'b1, ZQINIT_CYC);
		zq(1'b1, ZQOPER_CYC);
		zq(1'b0, ZQCS_CYC);
		act(3'h3, 14'($random(seed)));
		act(3'h5, 14'($random(seed)));
		pre(3'h3, 1'b0);
		pre(3'h3, 1'b0);
		pre(3'h0, 1'b1);
		// Stalled array port: an eight and a four beat write overflow the buffer.
		stall = 1'b1;
		act(3'h1, 14'($random(seed)));
		act(3'h6, 14'($random(seed)));
		burst(1'b1, 3'h1, 10'($random(seed)), 1'b0, 1'b1, 1'b0);
		burst(1'b1, 3'h6, 10'($random(seed)), 1'b1, 1'b0, 1'b0);
		chk("buffer refused", 1, full_seen);
		for (int i = 0; i < 12; i++) begin
			otf_enable = 1'($random(seed));
			burst_length_fixed_by_mode = 1'($random(seed));
			b = 3'($random(seed));
			act(b, 14'($random(seed)));
			burst(i[0], b, 10'($random(seed)), 1'($random(seed)), 1'($random(seed)), i == 2);
		end
		pre(3'h0, 1'b1);
		// Each refresh steps the internal row once; the bus only idles meanwhile.
		// Two refreshes sit far inside the interval, posting and burst limits.
		for (int i = 0; i < 2; i++) begin
			r0 = ref_row;
			rc = 0;
			ctl.cmd(P_REF, 3'($random(seed)), 14'($random(seed)));
			repeat (RFC_CYC + 4) @(negedge clk_sys);
			chk("ref_busy cycles", RFC_CYC, rc);
			chk("ref_row", 14'(r0 + 14'h0001), ref_row);
		end
		chk("buffered words", ew.size(), wq.size());
		for (int i = 0; i < ew.size(); i++) begin
			chk("buffered word", ew[i], wq[i]);
		end
		test_done();
	end
endmodule
